// ### logic/flash_host_cfg.svh
// Timing and field constants for the parallel flash bus host.
// Assumes a 200 MHz clock; times are in ns and cycle counts derive from them.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CLK_PERIOD_NS       5
// Address / chip-select access time of the slowest speed grade
`define ACCESS_TIME_NS      90
`define ACCESS_CYCLES       ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write-enable low width and recovery between bus cycles
`define WRITE_PULSE_NS      35
`define WRITE_PULSE_CYCLES  ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_NS         20
`define RECOVERY_CYCLES     ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Hardware reset pulse width
`define RESET_PULSE_NS      500
`define RESET_PULSE_CYCLES  ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_EXTRA_NS      30

// Protect cycle address fields
`define PROT_BIT_UNPROT     6
`define PROT_BIT_A1         1
`define PROT_BIT_A0         0

`define ADDR_W              17
`define DATA_W              8
`define CNT_W               8

`endif

// ### logic/flash_host_pkg.sv
// Types for the parallel flash bus host.
// Assumes flash_host_cfg.svh supplies the numeric constants.
package flash_host_pkg;

    typedef enum logic [2:0] {
        OP_READ      = 3'h0,
        OP_WRITE     = 3'h1,
        OP_PROTECT   = 3'h2,
        OP_UNPROTECT = 3'h3,
        OP_RESET     = 3'h4
    } op_t;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_READ    = 6'h02,
        ST_WRITE   = 6'h04,
        ST_RECOVER = 6'h08,
        ST_RESET   = 6'h10,
        ST_DONE    = 6'h20
    } state_t;

endpackage : flash_host_pkg

// ### logic/flash_host.sv
// Host-side bus controller for a byte-wide parallel flash memory.
// Assumes one 200 MHz clock, a synchronous active-high reset, and that the
// pad ring resolves the data pins from data_oe; the flash itself is clockless.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Read: select and output enable low, write high.
// - Write: write and select low, output high.
// - Bypass programming takes two writes, not four.
// - Allow full select access time after standby.
// - Protect: select low, output high, write low.
module flash_host
    import flash_host_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // User request side
    input  wire logic                 req_valid,
    input  wire op_t                  req_op,
    input  wire logic [`ADDR_W-1:0]   req_addr,
    input  wire logic [`DATA_W-1:0]   req_data,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [`DATA_W-1:0]        rsp_data,
    // Flash pins
    output logic [`ADDR_W-1:0]        address_lines,
    output logic [`DATA_W-1:0]        data_out,
    output logic                      data_oe,
    input  wire logic [`DATA_W-1:0]   data_in,
    output logic                      chip_sel_n,
    output logic                      out_en_n,
    output logic                      write_en_n,
    output logic                      reset_n,
    output logic                      elevated_id_voltage
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser; the first stage feeds only the second

    logic [`DATA_W-1:0] data_meta;
    logic [`DATA_W-1:0] data_sync;

    always_ff @(posedge clk) begin
        data_meta <= data_in;
        data_sync <= data_meta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer

    function automatic logic [`CNT_W-1:0] cycles(input int n);
        cycles = n[`CNT_W-1:0];
    endfunction : cycles

    state_t             state, next_state;
    logic [`CNT_W-1:0]  count, next_count;
    logic [`ADDR_W-1:0] next_address;
    logic [`DATA_W-1:0] next_data_out, next_rsp_data;
    logic               next_data_oe, next_chip_sel_n, next_out_en_n;
    logic               next_write_en_n, next_reset_n, next_id_voltage;
    logic               next_req_ready, next_rsp_valid;

    always_comb begin
        next_state      = state;
        next_count      = count;
        next_address    = address_lines;
        next_data_out   = data_out;
        next_data_oe    = data_oe;
        next_chip_sel_n = chip_sel_n;
        next_out_en_n   = out_en_n;
        next_write_en_n = write_en_n;
        next_reset_n    = reset_n;
        next_id_voltage = elevated_id_voltage;
        next_req_ready  = 1'b0;
        next_rsp_valid  = 1'b0;
        next_rsp_data   = rsp_data;
        case (state)
            ST_IDLE: begin
                // Idle keeps select and reset high: standby, data floating
                next_chip_sel_n = 1'b1;
                next_out_en_n   = 1'b1;
                next_write_en_n = 1'b1;
                next_data_oe    = 1'b0;
                next_id_voltage = 1'b0;
                next_req_ready  = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_address   = req_addr;
                    next_data_out  = req_data;
                    case (req_op)
                        OP_READ: begin
                            // Counting from select assertion covers standby exit
                            next_chip_sel_n = 1'b0;
                            next_out_en_n   = 1'b0;
                            next_count      = cycles(`ACCESS_CYCLES);
                            next_state      = ST_READ;
                        end
                        OP_WRITE: begin
                            // Output enable stays high so the device never drives
                            next_chip_sel_n = 1'b0;
                            next_write_en_n = 1'b0;
                            next_data_oe    = 1'b1;
                            next_count      = cycles(`WRITE_PULSE_CYCLES);
                            next_state      = ST_WRITE;
                        end
                        OP_PROTECT, OP_UNPROTECT: begin
                            next_address[`PROT_BIT_UNPROT] =
                                (req_op == OP_UNPROTECT);
                            next_address[`PROT_BIT_A1] = 1'b1;
                            next_address[`PROT_BIT_A0] = 1'b0;
                            next_id_voltage = 1'b1;
                            next_chip_sel_n = 1'b0;
                            next_write_en_n = 1'b0;
                            next_data_oe    = 1'b1;
                            next_count      = cycles(`WRITE_PULSE_CYCLES);
                            next_state      = ST_WRITE;
                        end
                        OP_RESET: begin
                            next_reset_n = 1'b0;
                            next_count   = cycles(`RESET_PULSE_CYCLES);
                            next_state   = ST_RESET;
                        end
                        default: begin
                            next_state = ST_DONE;
                        end
                    endcase
                end
            end
            ST_READ: begin
                // Address held still; device may sleep yet keeps data valid
                if (count > cycles(1)) begin
                    next_count = count - cycles(1);
                end else begin
                    // Sample synchronised data after two extra settle stages
                    next_count = cycles(2);
                    next_state = ST_DONE;
                end
            end
            ST_WRITE: begin
                if (count > cycles(1)) begin
                    next_count = count - cycles(1);
                end else begin
                    // Rising write enable is where the device latches
                    next_write_en_n = 1'b1;
                    next_count      = cycles(`RECOVERY_CYCLES);
                    next_state      = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (count > cycles(1)) begin
                    next_count = count - cycles(1);
                end else begin
                    // Deselect is safe: a running program/erase carries on
                    next_chip_sel_n = 1'b1;
                    next_data_oe    = 1'b0;
                    next_id_voltage = 1'b0;
                    next_rsp_valid  = 1'b1;
                    next_state      = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (count > cycles(1)) begin
                    next_count = count - cycles(1);
                end else begin
                    // Device is back in array read after release
                    next_reset_n   = 1'b1;
                    next_rsp_valid = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            ST_DONE: begin
                // Read: wait for the pin synchroniser, then deliver the byte
                if (count > cycles(0)) begin
                    next_count = count - cycles(1);
                end else begin
                    next_rsp_data   = data_sync;
                    next_rsp_valid  = 1'b1;
                    next_chip_sel_n = 1'b1;
                    next_out_en_n   = 1'b1;
                    next_state      = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state               <= ST_IDLE;
            count               <= '0;
            address_lines       <= '0;
            data_out            <= '0;
            data_oe             <= 1'b0;
            chip_sel_n          <= 1'b1;
            out_en_n            <= 1'b1;
            write_en_n          <= 1'b1;
            reset_n             <= 1'b1;
            elevated_id_voltage <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_data            <= '0;
        end else begin
            state               <= next_state;
            count               <= next_count;
            address_lines       <= next_address;
            data_out            <= next_data_out;
            data_oe             <= next_data_oe;
            chip_sel_n          <= next_chip_sel_n;
            out_en_n            <= next_out_en_n;
            write_en_n          <= next_write_en_n;
            reset_n             <= next_reset_n;
            elevated_id_voltage <= next_id_voltage;
            req_ready           <= next_req_ready;
            rsp_valid           <= next_rsp_valid;
            rsp_data            <= next_rsp_data;
        end
    end

endmodule : flash_host

// ### tb/flash_host_chk.sv
// Pin-level checks for the flash bus host.
// Assumes it is bound onto flash_host and sees its ports.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_chk
    import flash_host_pkg::*;
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               req_valid,
    input wire op_t                req_op,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    input wire logic [`ADDR_W-1:0] address_lines,
    input wire logic               data_oe,
    input wire logic               chip_sel_n,
    input wire logic               out_en_n,
    input wire logic               write_en_n,
    input wire logic               reset_n,
    input wire logic               elevated_id_voltage
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
sequence s_take(op_t o);
    req_valid && req_ready && req_op == o;
endsequence
sequence s_wr_pulse;
    !write_en_n [*7] ##1 write_en_n;
endsequence
sequence s_read_end;
    (!out_en_n && !rsp_valid) ##3 rsp_valid;
endsequence
sequence s_reset_pulse;
    !reset_n ##100 (reset_n && rsp_valid);
endsequence
property p_read_pins;
    !out_en_n |-> !chip_sel_n && write_en_n && reset_n && !data_oe;
endproperty
property p_write_pins;
    !write_en_n && !elevated_id_voltage |-> !chip_sel_n && out_en_n && data_oe && reset_n;
endproperty
property p_prot_pins;
    !write_en_n && elevated_id_voltage |->
        !chip_sel_n && out_en_n && address_lines[1] && !address_lines[0];
endproperty
property p_prot_bit;
    s_take(OP_PROTECT) |=> elevated_id_voltage && !address_lines[6];
endproperty
property p_unprot_bit;
    s_take(OP_UNPROTECT) |=> elevated_id_voltage && address_lines[6];
endproperty
property p_read_wait;
    s_take(OP_READ) |-> ##19 s_read_end;
endproperty
property p_write_walk;
    s_take(OP_WRITE) |-> ##1 s_wr_pulse ##4 rsp_valid;
endproperty
property p_reset_walk;
    s_take(OP_RESET) |-> ##1 s_reset_pulse;
endproperty
a_read_pins: assert property (p_read_pins) else $error("read pin levels wrong");
a_write_pins: assert property (p_write_pins) else $error("write pin levels wrong");
a_prot_pins: assert property (p_prot_pins) else $error("protect pins wrong");
a_prot_bit: assert property (p_prot_bit) else $error("protect address bit wrong");
a_unprot_bit: assert property (p_unprot_bit) else $error("unprotect bit wrong");
a_read_wait: assert property (p_read_wait) else $error("read access too short");
a_write_walk: assert property (p_write_walk) else $error("write pulse wrong");
a_reset_walk: assert property (p_reset_walk) else $error("reset pulse wrong");
endmodule : flash_host_chk
bind flash_host flash_host_chk i_chk (.*);

// ### tb/flash_model.sv
// Behavioural byte-wide flash on the far side of the host.
// Assumes clockless pins; the data pins resolve here from both enables.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_model #(
    parameter int         ACC_NS  = 90,
    parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary identification value
) (
    input wire logic [`ADDR_W-1:0] address_lines,
    input wire logic [7:0]         data_out,
    input wire logic               data_oe,
    input wire logic               chip_sel_n,
    input wire logic               out_en_n,
    input wire logic               write_en_n,
    input wire logic               reset_n,
    input wire logic               elevated_id_voltage,
    output logic [7:0]             data_in
);
logic id_mode = 1'b0;
logic rd_ok   = 1'b0;
int   tok     = 0;
logic [7:0] rd_val;
// Commands live only in latches, never in the array
always @(posedge write_en_n or negedge reset_n) begin
    if (!reset_n) id_mode <= 1'b0;
    else if (!chip_sel_n && out_en_n && !elevated_id_voltage) begin
        if (data_out == 8'h90) id_mode <= 1'b1;
        if (data_out == 8'hf0) id_mode <= 1'b0;
    end
end
// Any change restarts the access time, so early sampling sees garbage
always @(chip_sel_n, out_en_n, reset_n, address_lines) begin
    tok++;
    rd_ok = 1'b0;
    fork
        automatic int t = tok;
        begin
            #(ACC_NS);
            if (t == tok) rd_ok = 1'b1;
        end
    join_none
end
assign rd_val = id_mode ? ID_CODE : address_lines[7:0] ^ address_lines[16:9];
// Outputs are valid only when ready, selected, enabled and out of reset
// Released lines show the inverse byte; data holds while address rests
assign data_in = data_oe ? data_out : (rd_ok && !chip_sel_n && !out_en_n && reset_n) ? rd_val : ~rd_val;
endmodule : flash_model

// ### tb/parallel_flash_bus_operations_test.sv
// Self-checking bench for the flash bus host against a flash model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module parallel_flash_bus_operations_test;
import flash_host_pkg::*;
logic        clk = 0, sys_rst = 1, req_valid = 0;
op_t         req_op = OP_READ;
logic [16:0] req_addr = 17'h0, address_lines;
logic [7:0]  req_data = 8'h0, rsp_data, data_out, data_in, q;
logic        req_ready, rsp_valid, data_oe, chip_sel_n, out_en_n, write_en_n;
logic        reset_n, elevated_id_voltage;
int          n_fail = 0, checked = 0;
flash_host  i_dut (.*);
flash_model i_flash (.*);
always #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask : wrap_up
task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
        n_fail++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
endtask : chk
task automatic run(op_t op, logic [16:0] a, logic [7:0] d, output logic [7:0] r);
    int i;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    i = 0;
    // Strict compares so an unknown handshake never looks like a grant
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 300);
    req_valid <= 1'b0;
    do begin @(posedge clk); i++; end while (rsp_valid !== 1'b1 && i < 300);
    r = rsp_data;
    if (i >= 300) begin
        n_fail++;
        wrap_up();
    end
endtask : run
function automatic logic [7:0] arr(logic [16:0] a);
    return a[7:0] ^ a[16:9];
endfunction : arr
////////////////////////////////////////////////////////////////////////////////
task automatic t_read();
    logic [16:0] a[3] = '{17'h00000, 17'h1a5c3, 17'h1ffff};
    foreach (a[k]) begin
        run(OP_READ, a[k], 8'h0, q);
        chk("array byte", arr(a[k]), q);
    end
    chk("standby select", 8'h1, {7'h0, chip_sel_n});
endtask : t_read
task automatic t_ident();
    run(OP_WRITE, 17'h00555, 8'h90, q);
    run(OP_READ, 17'h00001, 8'h0, q);
    chk("id code", 8'h3c, q);
    run(OP_WRITE, 17'h00000, 8'hf0, q);
    run(OP_READ, 17'h0bb01, 8'h0, q);
    chk("array after exit", arr(17'h0bb01), q);
    chk("write released", 8'h0, {7'h0, data_oe});
endtask : t_ident
task automatic t_hw_reset();
    run(OP_WRITE, 17'h00555, 8'h90, q);
    run(OP_RESET, 17'h0, 8'h0, q);
    chk("reset pin back", 8'h1, {7'h0, reset_n});
    run(OP_READ, 17'h00001, 8'h0, q);
    chk("array after reset", arr(17'h00001), q);
endtask : t_hw_reset
task automatic t_protect();
    run(OP_PROTECT, 17'h1c0ff, 8'h0, q);
    chk("protect addr", 8'h2, {5'h0, address_lines[6], address_lines[1:0]});
    run(OP_UNPROTECT, 17'h04000, 8'h0, q);
    chk("unprotect addr", 8'h6, {5'h0, address_lines[6], address_lines[1:0]});
endtask : t_protect
task automatic t_bypass();
    run(OP_WRITE, 17'h00000, 8'ha0, q);
    run(OP_WRITE, 17'h12345, 8'h5a, q);
    chk("write pin idle", 8'h1, {7'h0, write_en_n});
endtask : t_bypass
initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("idle reset pin", 8'h1, {7'h0, reset_n});
    t_read();
    t_ident();
    t_hw_reset();
    t_protect();
    t_bypass();
    wrap_up();
end
endmodule : parallel_flash_bus_operations_test
